/* logic/rail_seq_pkg.sv */
// Constants shared by the rail sequencer: register map, field positions, reset values, timing.
// Assumes a 40 MHz clock and one AHB-Lite master.
//
// Behaviour
// - Over-temperature shuts converters only while fixed-frequency mode is forced or automatic.
// - Both linear regulators start enabled; software may disable or retune them.
// - Linear regulator flags set at 10% low, clear at 5% low; readable in status.
// - Any monitored rail dropping below its power-good threshold raises an interrupt.
// - Second linear regulator comparator gives no flag or interrupt while disabled.
// - Lockout threshold resets to the 2.75 V code and is software reprogrammable.
// - Supply lockout drives supply fail low, then ordered shutdown after lockout delay.
// - Over-temperature follows the same procedure after its own delay.
// - Regulators restart on their own once the fault has cleared.
// - Charger has separate lockout on adapter and bus inputs, independent of main.
// - Order strap 0 ramps core first and down last; 1 ramps I/O first.
// - Core default strap selects 1.3 V low, 1.6 V high.
// - I/O default strap selects 1.8 V low, 3.3 V high.
// - In low-power mode the core rail moves to the sleep preset voltage.
// - With sleep core off set, the core rail switches off in low-power mode.
// - Sleep request pin is ignored while the sleep enable bit is clear.
// - Low-power entry only on a rising edge of sleep pin AND sleep enable.
// - Low-power exits on pin low, enable cleared, push-button wake or warm reset.
// - Wait mode with adapter or bus present needs the wait allow bit, bit 7.
// - Bit 7 of the first converter control register forces fixed-frequency mode.
// - Push-button exit restores the pre-sleep core voltage and raises a maskable interrupt.
package rail_seq_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] CONV1_ADDR = 8'h00;
  localparam logic [7:0] CONV2_ADDR = 8'h04;
  localparam logic [7:0] REGCTL_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0C;
  localparam logic [7:0] LOCKOUT_ADDR = 8'h10;
  localparam logic [7:0] CHGCFG_ADDR = 8'h14;
  localparam logic [7:0] INTSTAT_ADDR = 8'h18;
  localparam logic [7:0] INTMASK_ADDR = 8'h1C;

  // ==========================================================================
  // Field positions
  localparam int FORCE_FF_BIT = 7;
  localparam int SLEEP_EN_BIT = 6;
  localparam int SLEEP_CORE_OFF_BIT = 4;
  localparam int FIRST_LINEAR_REGULATOR_EN_BIT = 8;
  localparam int SECOND_LINEAR_REGULATOR_EN_BIT = 9;
  localparam int WAIT_ALLOW_BIT = 7;
  localparam int PB_INT_BIT = 4;

  // ==========================================================================
  // Reset values and voltage codes
  localparam logic [3:0] CORE_1V3_CODE = 4'h3;
  localparam logic [3:0] CORE_1V6_CODE = 4'h6;
  localparam logic [3:0] IO_1V8_CODE = 4'h8;
  localparam logic [3:0] IO_3V3_CODE = 4'hD;
  localparam logic [3:0] SLEEP_PRESET_RST = 4'h1;
  localparam logic [7:0] LDO_SET_RST = 8'h00;
  localparam logic [4:0] LOCKOUT_2V75_CODE = 5'h0B;
  localparam logic [4:0] INT_MASK_RST = 5'h1F;

  // ==========================================================================
  // Synchroniser vector layout
  localparam int SY_SLEEP = 0;
  localparam int SY_LOCKOUT = 1;
  localparam int SY_HOT = 2;
  localparam int SY_AUTO_FF = 3;
  localparam int SY_ADP_LOW = 4;
  localparam int SY_BUS_LOW = 5;
  localparam int SY_PB = 6;
  localparam int SY_WRST_N = 7;
  localparam int SY_TRIP = 8;
  localparam int SY_REL = 12;
  localparam int SY_W = 16;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int LOCKOUT_DELAY_NS = 1000;
  localparam int HOT_DELAY_NS = 1000;
  localparam int RAMP_STEP_NS = 2000;
  localparam int DEBOUNCE_NS = 1000;
  localparam int LOCKOUT_DELAY_CYC = (LOCKOUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOT_DELAY_CYC = (HOT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* logic/rail_sequencer_sleep_control.sv */
// Rail sequencer, fault shutdown and low-power control with an AHB-Lite register slave.
// Assumes async comparator and pin inputs and an analog side that obeys the enables.
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module rail_sequencer_sleep_control #(
  parameter int CNT_W = 16,
  parameter int DEBOUNCE_CYC = rail_seq_pkg::DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Straps and pins
  input wire logic sequence_order_strap,
  input wire logic core_default_strap,
  input wire logic io_default_strap,
  input wire logic sleep_request_pin,
  input wire logic push_button_wake,
  input wire logic warm_reset_input_n,
  // Comparators: index 0 core, 1 I/O, 2 first linear, 3 second linear
  input wire logic supply_below_lockout,
  input wire logic over_temperature,
  input wire logic auto_fixed_frequency,
  input wire logic [3:0] rail_trip_low,
  input wire logic [3:0] rail_release_ok,
  input wire logic adapter_below_charger_lockout,
  input wire logic bus_below_charger_lockout,
  // Controls to the analog side
  output logic supply_fail_output_n,
  output logic core_rail_en,
  output logic io_rail_en,
  output logic [3:0] core_rail_code,
  output logic [3:0] io_rail_code,
  output logic fixed_frequency,
  output logic first_linear_regulator_en,
  output logic second_linear_regulator_en,
  output logic [3:0] first_linear_regulator_code,
  output logic [3:0] second_linear_regulator_code,
  output logic [4:0] lockout_threshold_code,
  output logic charger_input_valid,
  output logic low_power,
  output logic wait_mode,
  output logic irq_n
);

  if (CNT_W < 8 || DEBOUNCE_CYC < 1 || DEBOUNCE_CYC >= (1 << CNT_W)) begin : g_bad_params
    $error("rail_sequencer_sleep_control: counter too narrow for the configured delays.");
  end

  typedef enum logic [2:0] {ST_OFF, ST_UP1, ST_UP2, ST_ON, ST_FAILWAIT, ST_DOWN1, ST_DOWN2} seq_t;

  // ==========================================================================
  // Input synchronisers
  logic [rail_seq_pkg::SY_W-1:0] raw_in;
  logic [rail_seq_pkg::SY_W-1:0] sync1_r;
  logic [rail_seq_pkg::SY_W-1:0] sync_r;

  assign raw_in = {rail_release_ok, rail_trip_low, warm_reset_input_n, push_button_wake,
                   bus_below_charger_lockout, adapter_below_charger_lockout, auto_fixed_frequency,
                   over_temperature, supply_below_lockout, sleep_request_pin};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_r <= '0;
      sync_r <= '0;
    end else if (ce) begin
      sync1_r <= raw_in;
      sync_r <= sync1_r;
    end
  end

  // ==========================================================================
  // Debounce of push-button wake and warm reset
  logic [1:0] db_in;
  logic [1:0] db_r;
  logic [1:0] db_prev_r;

  assign db_in = {~sync_r[rail_seq_pkg::SY_WRST_N], sync_r[rail_seq_pkg::SY_PB]};

  for (genvar i = 0; i < 2; i++) begin : g_debounce
    logic [CNT_W-1:0] cnt_r;
    logic q_r;
    assign db_r[i] = q_r;
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        cnt_r <= '0;
        q_r <= 1'b0;
      end else if (ce) begin
        if (db_in[i] == q_r) begin
          cnt_r <= '0;
        end else if (cnt_r == CNT_W'(DEBOUNCE_CYC - 1)) begin
          cnt_r <= '0;
          q_r <= db_in[i];
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  wire pb_event = db_r[0] & ~db_prev_r[0];
  wire wrst_event = db_r[1] & ~db_prev_r[1];

  // ==========================================================================
  // Register file
  logic [7:0] conv1_r;
  logic [7:0] conv2_r;
  logic [9:0] regctl_r;
  logic [4:0] lockout_r;
  logic [7:0] chgcfg_r;
  logic [4:0] int_stat_r;
  logic [4:0] int_mask_r;
  logic [3:0] core_code_r;
  logic [3:0] io_code_r;
  logic order_r;
  logic straps_done_r;

  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;

  wire addr_phase = hsel & hready & htrans[1];
  wire [7:0] a_addr = haddr[7:0];
  wire wr_conv1 = wr_pend_r && wr_addr_r == rail_seq_pkg::CONV1_ADDR;
  wire wr_conv2 = wr_pend_r && wr_addr_r == rail_seq_pkg::CONV2_ADDR;
  wire wr_regctl = wr_pend_r && wr_addr_r == rail_seq_pkg::REGCTL_ADDR;
  wire wr_lockout = wr_pend_r && wr_addr_r == rail_seq_pkg::LOCKOUT_ADDR;
  wire wr_chgcfg = wr_pend_r && wr_addr_r == rail_seq_pkg::CHGCFG_ADDR;
  wire wr_intstat = wr_pend_r && wr_addr_r == rail_seq_pkg::INTSTAT_ADDR;
  wire wr_intmask = wr_pend_r && wr_addr_r == rail_seq_pkg::INTMASK_ADDR;

  wire force_ff = conv1_r[rail_seq_pkg::FORCE_FF_BIT];
  wire sleep_en = conv1_r[rail_seq_pkg::SLEEP_EN_BIT];
  wire core_off_in_sleep = conv2_r[rail_seq_pkg::SLEEP_CORE_OFF_BIT];
  wire [3:0] sleep_preset = conv2_r[3:0];

  // ==========================================================================
  // Power-good flags with hysteresis
  logic [3:0] pg_bad_r;
  logic [3:0] rail_on;
  logic [3:0] pg_bad_nxt;
  logic [3:0] pg_fall;
  wire [3:0] trip_s = sync_r[rail_seq_pkg::SY_TRIP +: 4];
  wire [3:0] rel_s = sync_r[rail_seq_pkg::SY_REL +: 4];

  for (genvar r = 0; r < 4; r++) begin : g_pg
    // A disabled rail's comparator is held inactive so it cannot flag or interrupt.
    assign pg_bad_nxt[r] = rail_on[r] & (trip_s[r] | (pg_bad_r[r] & ~rel_s[r]));
    assign pg_fall[r] = pg_bad_nxt[r] & ~pg_bad_r[r];
  end

  // ==========================================================================
  // Sequencer
  seq_t state_r;
  seq_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic core_on_r;
  logic io_on_r;
  logic ldo_on_r;
  logic fail_hot_r;

  wire fixed_mode = force_ff | sync_r[rail_seq_pkg::SY_AUTO_FF];
  wire hot_fault = sync_r[rail_seq_pkg::SY_HOT] & fixed_mode;
  wire lock_fault = sync_r[rail_seq_pkg::SY_LOCKOUT];
  wire fault = hot_fault | lock_fault;
  wire cnt_done = cnt_r == '0;
  wire [CNT_W-1:0] step_cyc = CNT_W'(rail_seq_pkg::RAMP_STEP_CYC - 1);
  wire [CNT_W-1:0] fail_cyc = hot_fault & ~lock_fault ? CNT_W'(rail_seq_pkg::HOT_DELAY_CYC - 1)
                                                      : CNT_W'(rail_seq_pkg::LOCKOUT_DELAY_CYC - 1);
  // First-up rail is the core rail when the order strap is low.
  wire first_is_core = ~order_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - 1'b1;
    unique case (state_r)
      ST_OFF: begin
        if (straps_done_r && !fault) begin
          state_nxt = ST_UP1;
          cnt_nxt = step_cyc;
        end
      end
      ST_UP1: begin
        if (fault) begin
          state_nxt = ST_FAILWAIT;
          cnt_nxt = fail_cyc;
        end else if (cnt_done) begin
          state_nxt = ST_UP2;
          cnt_nxt = step_cyc;
        end
      end
      ST_UP2: begin
        if (fault) begin
          state_nxt = ST_FAILWAIT;
          cnt_nxt = fail_cyc;
        end else if (cnt_done) begin
          state_nxt = ST_ON;
        end
      end
      ST_ON: begin
        if (fault) begin
          state_nxt = ST_FAILWAIT;
          cnt_nxt = fail_cyc;
        end
      end
      ST_FAILWAIT: begin
        if (cnt_done) begin
          state_nxt = ST_DOWN1;
          cnt_nxt = step_cyc;
        end
      end
      ST_DOWN1: begin
        if (cnt_done) begin
          state_nxt = ST_DOWN2;
          cnt_nxt = step_cyc;
        end
      end
      ST_DOWN2: begin
        if (cnt_done) begin
          state_nxt = ST_OFF;
        end
      end
    endcase
  end

  // Rail enables per state; the first rail to come up is the last to go down.
  wire first_up = state_r inside {ST_UP1, ST_UP2, ST_ON, ST_FAILWAIT, ST_DOWN1};
  wire second_up = state_r inside {ST_UP2, ST_ON, ST_FAILWAIT};
  wire all_up = first_up;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= ST_OFF;
      cnt_r <= '0;
      fail_hot_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (state_nxt == ST_FAILWAIT && state_r != ST_FAILWAIT) begin
        fail_hot_r <= hot_fault & ~lock_fault;
      end
    end
  end

  // ==========================================================================
  // Low-power mode
  logic sleep_and_prev_r;
  logic lp_r;
  wire sleep_pin_s = sync_r[rail_seq_pkg::SY_SLEEP];
  wire sleep_and = sleep_pin_s & sleep_en;
  wire lp_enter = sleep_and & ~sleep_and_prev_r & (state_r == ST_ON);
  wire lp_exit = ~sleep_pin_s | ~sleep_en | pb_event | wrst_event | (state_r != ST_ON);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sleep_and_prev_r <= 1'b0;
      lp_r <= 1'b0;
      db_prev_r <= '0;
    end else if (ce) begin
      sleep_and_prev_r <= sleep_and;
      db_prev_r <= db_r;
      if (lp_r && lp_exit) begin
        lp_r <= 1'b0;
      end else if (lp_enter) begin
        lp_r <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Register writes, straps and interrupt status
  wire [4:0] int_set = {pb_event & lp_r, pg_fall};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      conv1_r <= '0;
      conv2_r <= {4'h0, rail_seq_pkg::SLEEP_PRESET_RST};
      regctl_r <= {2'b11, rail_seq_pkg::LDO_SET_RST};
      lockout_r <= rail_seq_pkg::LOCKOUT_2V75_CODE;
      chgcfg_r <= '0;
      int_stat_r <= '0;
      int_mask_r <= rail_seq_pkg::INT_MASK_RST;
      core_code_r <= '0;
      io_code_r <= '0;
      order_r <= 1'b0;
      straps_done_r <= 1'b0;
      pg_bad_r <= '0;
    end else if (ce) begin
      pg_bad_r <= pg_bad_nxt;
      if (!straps_done_r) begin
        straps_done_r <= 1'b1;
        order_r <= sequence_order_strap;
        core_code_r <= core_default_strap ? rail_seq_pkg::CORE_1V6_CODE
                                          : rail_seq_pkg::CORE_1V3_CODE;
        io_code_r <= io_default_strap ? rail_seq_pkg::IO_3V3_CODE : rail_seq_pkg::IO_1V8_CODE;
      end else if (wr_conv1) begin
        core_code_r <= hwdata[3:0];
      end
      if (wr_conv1) begin
        conv1_r <= {hwdata[7:6], 2'b00, conv1_r[3:0]};
      end
      if (wr_conv2) begin
        conv2_r <= {3'b000, hwdata[4:0]};
      end
      if (wr_regctl) begin
        regctl_r <= hwdata[9:0];
      end
      if (wr_lockout) begin
        lockout_r <= hwdata[4:0];
      end
      if (wr_chgcfg) begin
        chgcfg_r <= hwdata[7:0];
      end
      if (wr_intmask) begin
        int_mask_r <= hwdata[4:0];
      end
      // A new event in the clearing cycle survives the write-one-to-clear.
      int_stat_r <= (int_stat_r & ~(wr_intstat ? hwdata[4:0] : 5'h00)) | int_set;
    end
  end

  // ==========================================================================
  // Bus slave: no wait states, read data registered at the address phase
  wire adapter_ok = ~sync_r[rail_seq_pkg::SY_ADP_LOW];
  wire bus_ok = ~sync_r[rail_seq_pkg::SY_BUS_LOW];
  wire [31:0] status_word = {18'h0, io_code_r, adapter_ok, bus_ok, io_on_r, core_on_r,
                             ~supply_fail_output_n, lp_r, pg_bad_r};
  logic [31:0] rd_word;

  always_comb begin
    unique case (a_addr)
      rail_seq_pkg::CONV1_ADDR: rd_word = {24'h0, conv1_r[7:4], core_code_r};
      rail_seq_pkg::CONV2_ADDR: rd_word = {24'h0, conv2_r};
      rail_seq_pkg::REGCTL_ADDR: rd_word = {22'h0, regctl_r};
      rail_seq_pkg::STATUS_ADDR: rd_word = status_word;
      rail_seq_pkg::LOCKOUT_ADDR: rd_word = {27'h0, lockout_r};
      rail_seq_pkg::CHGCFG_ADDR: rd_word = {24'h0, chgcfg_r};
      rail_seq_pkg::INTSTAT_ADDR: rd_word = {27'h0, int_stat_r};
      rail_seq_pkg::INTMASK_ADDR: rd_word = {27'h0, int_mask_r};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      hrdata_r <= '0;
    end else if (ce) begin
      wr_pend_r <= addr_phase & hwrite;
      wr_addr_r <= a_addr;
      if (addr_phase && !hwrite) begin
        hrdata_r <= rd_word;
      end
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================================
  // Outputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      core_on_r <= 1'b0;
      io_on_r <= 1'b0;
      ldo_on_r <= 1'b0;
    end else if (ce) begin
      core_on_r <= (first_is_core ? first_up : second_up) & ~(lp_r & core_off_in_sleep);
      io_on_r <= first_is_core ? second_up : first_up;
      ldo_on_r <= all_up;
    end
  end

  assign rail_on = {ldo_on_r & regctl_r[rail_seq_pkg::SECOND_LINEAR_REGULATOR_EN_BIT],
                    ldo_on_r & regctl_r[rail_seq_pkg::FIRST_LINEAR_REGULATOR_EN_BIT], io_on_r, core_on_r};
  assign core_rail_en = core_on_r;
  assign io_rail_en = io_on_r;
  // Sleep never touches the normal code, so every exit restores it.
  assign core_rail_code = lp_r ? sleep_preset : core_code_r;
  assign io_rail_code = io_code_r;
  assign fixed_frequency = force_ff;
  assign first_linear_regulator_en = rail_on[2];
  assign second_linear_regulator_en = rail_on[3];
  assign first_linear_regulator_code = regctl_r[3:0];
  assign second_linear_regulator_code = regctl_r[7:4];
  assign lockout_threshold_code = lockout_r;
  assign charger_input_valid = adapter_ok | bus_ok;
  assign supply_fail_output_n = ~(fault | state_r inside {ST_FAILWAIT, ST_DOWN1, ST_DOWN2});
  assign low_power = lp_r;
  assign wait_mode = lp_r & (~(adapter_ok | bus_ok) | chgcfg_r[rail_seq_pkg::WAIT_ALLOW_BIT]);
  assign irq_n = ~|(int_stat_r & int_mask_r);

endmodule

`default_nettype wire

/* tb/rail_seq_asserts.sv */
// Port checks for the rail sequencer.
// Assumes one clock and a synchronous reset_n.
`timescale 1ns/1ps
`default_nettype none
module rail_seq_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sequence_order_strap,
  input wire logic sleep_request_pin,
  input wire logic supply_below_lockout,
  input wire logic adapter_below_charger_lockout,
  input wire logic [3:0] rail_trip_low,
  input wire logic supply_fail_output_n,
  input wire logic core_rail_en,
  input wire logic io_rail_en,
  input wire logic [4:0] lockout_threshold_code,
  input wire logic charger_input_valid,
  input wire logic low_power,
  input wire logic wait_mode,
  input wire logic irq_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  lock_reset_a: assert property ($rose(reset_n) |-> lockout_threshold_code == rail_seq_pkg::LOCKOUT_2V75_CODE)
    else $error("lockout reset");
  wait_lp_a: assert property (wait_mode |-> low_power)
    else $error("wait outside sleep");
  fail_first_a: assert property (supply_below_lockout [*3] |-> !supply_fail_output_n)
    else $error("no supply fail");
  fail_hold_a: assert property ($fell(supply_fail_output_n) |-> $stable(io_rail_en) [*8])
    else $error("early shutdown");
  up_order_a: assert property ($rose(io_rail_en) && !sequence_order_strap |-> core_rail_en)
    else $error("io up first");
  down_order_a: assert property ($fell(io_rail_en) && sequence_order_strap |-> !core_rail_en)
    else $error("io down first");
  chg_valid_a: assert property (!adapter_below_charger_lockout [*3] |-> charger_input_valid)
    else $error("charger invalid");
  rail_irq_a: assert property ((io_rail_en && rail_trip_low[1]) [*4] |=> !irq_n)
    else $error("no rail irq");
  lp_exit_a: assert property (!sleep_request_pin [*5] |-> !low_power)
    else $error("sleep held");
endmodule
bind rail_sequencer_sleep_control rail_seq_asserts chk_u (.clk, .reset_n, .sequence_order_strap,
  .sleep_request_pin, .supply_below_lockout, .adapter_below_charger_lockout, .rail_trip_low,
  .supply_fail_output_n, .core_rail_en, .io_rail_en, .lockout_threshold_code, .charger_input_valid,
  .low_power, .wait_mode, .irq_n);
`default_nettype wire

/* tb/host_sleep_model.sv */
// Host model driving the sleep pin.
// Assumes the bench clock; follows a command after 0 to 3 cycles.
`timescale 1ns/1ps
`default_nettype none
module host_sleep_model (
  input wire logic clk,
  input wire logic sleep_cmd,
  output logic sleep_request_pin
);
  int dly = 0;
  initial sleep_request_pin = 1'h0;
  // Re-entry is asked for only by a real toggle of the pin.
  always @(posedge clk) begin
    if (sleep_cmd !== sleep_request_pin) begin
      if (dly == 0) begin
        sleep_request_pin <= sleep_cmd;
        dly <= $urandom_range(3, 0);
      end else begin
        dly <= dly - 1;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Bench: register bus, sequencing, faults and low power.
// Assumes the host model drives the sleep pin.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'h0, reset_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, sleep_cmd = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, v;
  logic sequence_order_strap = 1'h0, core_default_strap = 1'h0, io_default_strap = 1'h0;
  logic push_button_wake = 1'h0, warm_reset_input_n = 1'h1, supply_below_lockout = 1'h0;
  logic over_temperature = 1'h0, adapter_below_charger_lockout = 1'h0;
  logic [3:0] rail_trip_low = 4'h0, rail_release_ok = 4'hF, core_rail_code, io_rail_code, cc, pre;
  logic hreadyout, sleep_request_pin, supply_fail_output_n, core_rail_en, io_rail_en, fixed_frequency;
  logic first_linear_regulator_en, charger_input_valid, low_power, wait_mode, irq_n;
  logic [4:0] lockout_threshold_code;
  int err_total = 0;
  int total_checks = 0;
  localparam logic [7:0] c1_adr = rail_seq_pkg::CONV1_ADDR;
  always #12.5 clk = ~clk;
  host_sleep_model host_u (.clk, .sleep_cmd, .sleep_request_pin);
  rail_sequencer_sleep_control #(.DEBOUNCE_CYC(2)) dut_u (.clk, .reset_n, .ce(1'h1), .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(),
    .sequence_order_strap, .core_default_strap, .io_default_strap, .sleep_request_pin, .push_button_wake,
    .warm_reset_input_n, .supply_below_lockout, .over_temperature, .auto_fixed_frequency(1'h0),
    .rail_trip_low, .rail_release_ok, .adapter_below_charger_lockout, .bus_below_charger_lockout(1'h1),
    .supply_fail_output_n, .core_rail_en, .io_rail_en, .core_rail_code, .io_rail_code, .fixed_frequency,
    .first_linear_regulator_en, .second_linear_regulator_en(), .first_linear_regulator_code(),
    .second_linear_regulator_code(), .lockout_threshold_code, .charger_input_valid, .low_power,
    .wait_mode, .irq_n);
  // ==========================================================================
  // Helpers
  function automatic logic [3:0] core_exp(input logic s);
    return s ? rail_seq_pkg::CORE_1V6_CODE : rail_seq_pkg::CORE_1V3_CODE;
  endfunction
  function automatic logic [3:0] io_exp(input logic s);
    return s ? rail_seq_pkg::IO_3V3_CODE : rail_seq_pkg::IO_1V8_CODE;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    ahb(1'h0, a, 32'h0);
    chk(n, e, q);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #(25 * 30000);
    err_total++;
    complete_run();
  end
  // ==========================================================================
  // Main sequence, per strap setting
  initial begin
    void'($urandom(32'h0C09));
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      reset_n <= 1'h0;
      sequence_order_strap <= s[0];
      core_default_strap <= s[0];
      io_default_strap <= ~s[0];
      cyc(2);
      reset_n <= 1'h1;
      cc = core_exp(s[0]);
      pre = 4'(cc + 4'h1 + 4'($urandom_range(7, 0)));
      cyc(300);
      chk("core code", 32'(cc), 32'(core_rail_code));
      chk("io code", 32'(io_exp(~s[0])), 32'(io_rail_code));
      rd(c1_adr, 32'(cc), "conv1");
      rd(rail_seq_pkg::REGCTL_ADDR, 32'h300, "regctl");
      rd(rail_seq_pkg::LOCKOUT_ADDR, 32'(rail_seq_pkg::LOCKOUT_2V75_CODE), "lockout");
      rd(8'h20, 32'h0, "unmapped");
      chk("ldo on", 32'h1, 32'(first_linear_regulator_en));
      v = 32'($urandom_range(31, 0));
      wr(rail_seq_pkg::LOCKOUT_ADDR, v);
      cyc(2);
      chk("lockout code", v, 32'(lockout_threshold_code));
      for (int k = 0; k < 3; k++) begin
        if (k == 2) wr(c1_adr, 32'h80 | 32'(cc));
        if (k == 0) supply_below_lockout <= 1'h1;
        else over_temperature <= 1'h1;
        cyc(20);
        chk("supply fail", 32'(k == 1), 32'(supply_fail_output_n));
        cyc(80);
        chk("second rail", 32'(k == 1), 32'(s[0] ? core_rail_en : io_rail_en));
        chk("first rail", 32'h1, 32'(s[0] ? io_rail_en : core_rail_en));
        cyc(100);
        chk("first off", 32'(k == 1), 32'(s[0] ? io_rail_en : core_rail_en));
        chk("ldo off", 32'(k == 1), 32'(first_linear_regulator_en));
        supply_below_lockout <= 1'h0;
        over_temperature <= 1'h0;
        cyc(300);
        chk("restart", 32'h3, 32'({core_rail_en, io_rail_en}));
      end
      chk("fixed freq", 32'h1, 32'(fixed_frequency));
      wr(c1_adr, 32'(cc));
      sleep_cmd <= 1'h1;
      cyc(20);
      chk("sleep ignored", 32'h0, 32'(low_power));
      sleep_cmd <= 1'h0;
      wr(rail_seq_pkg::CONV2_ADDR, 32'(pre));
      wr(c1_adr, 32'h40 | 32'(cc));
      cyc(20);
      for (int k = 0; k < 4; k++) begin
        sleep_cmd <= 1'h1;
        cyc(20);
        chk("enter", 32'h1, 32'(low_power));
        chk("sleep code", 32'(pre), 32'(core_rail_code));
        chk("wait", 32'(k != 0), 32'(wait_mode));
        case (k)
          0: sleep_cmd <= 1'h0;
          1: wr(c1_adr, 32'(cc));
          2: push_button_wake <= 1'h1;
          default: warm_reset_input_n <= 1'h0;
        endcase
        cyc(20);
        push_button_wake <= 1'h0;
        warm_reset_input_n <= 1'h1;
        chk("exit", 32'h0, 32'(low_power));
        chk("code back", 32'(cc), 32'(core_rail_code));
        if (k == 2) begin
          chk("wake irq", 32'h0, 32'(irq_n));
          rd(rail_seq_pkg::INTSTAT_ADDR, 32'h10, "wake flag");
          wr(rail_seq_pkg::INTSTAT_ADDR, 32'h1F);
        end
        if (k == 0) wr(rail_seq_pkg::CHGCFG_ADDR, 32'h80);
        if (k == 1) wr(c1_adr, 32'h40 | 32'(cc));
        else begin
          sleep_cmd <= 1'h0;
          cyc(20);
        end
      end
      wr(rail_seq_pkg::CONV2_ADDR, 32'h10 | 32'(pre));
      sleep_cmd <= 1'h1;
      cyc(20);
      chk("core off", 32'h0, 32'(core_rail_en));
      sleep_cmd <= 1'h0;
      cyc(20);
      chk("core on", 32'h1, 32'(core_rail_en));
      rail_trip_low <= 4'h2;
      rail_release_ok <= 4'hD;
      adapter_below_charger_lockout <= 1'h1;
      cyc(10);
      chk("rail irq", 32'h0, 32'(irq_n));
      chk("charger", 32'h0, 32'(charger_input_valid));
      rail_trip_low <= 4'h0;
      adapter_below_charger_lockout <= 1'h0;
      cyc(10);
      rd(rail_seq_pkg::STATUS_ADDR, 32'({io_exp(~s[0]), 10'h2C2}), "status");
      chk("flag held", 32'h2, 32'(q[3:0]));
      rail_release_ok <= 4'hF;
      wr(rail_seq_pkg::INTSTAT_ADDR, 32'h1F);
      cyc(10);
      ahb(1'h0, rail_seq_pkg::STATUS_ADDR, 32'h0);
      chk("flag clear", 32'h0, 32'(q[3:0]));
      chk("irq clear", 32'h1, 32'(irq_n));
    end
    complete_run();
  end
endmodule
`default_nettype wire
